//--- include/dsm_pkg.sv
// Purpose: Shared constants for the lane-masked DDR SRAM write path
// Assumes: One 36-bit word per burst beat, two beats per burst
// Notes:   Lanes are 9 bits wide, four per beat
package dsm_pkg;
  localparam int DATA_W      = 36;
  localparam int LANE_W      = 9;
  localparam int LANES       = 4;
  localparam int ADDR_W      = 19;
  localparam int BURST_BEATS = 2;
  localparam logic [LANES-1:0] MASK_RST = 4'hf;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;
endpackage : dsm_pkg

//--- rtl/dsm_ddr_sram_core.sv
// Purpose: Write-side lane masking and read path of a two-beat DDR SRAM core
// Assumes: Beats of one cycle arrive as a rise and a fall port pair, same clock
// Notes:   Read data appear two cycles after the read command
//
// Operation
// - Lane select 0 low on a write beat stores bits 8:0, else kept.
// - Lane select 1 low on a write beat stores bits 17:9, else kept.
// - Lane select 2 low on a write beat stores bits 26:18, else kept.
// - Lane select 3 low on a write beat stores bits 35:27, else kept.
// - All four selects low store the whole 36-bit beat.
// - All four selects high change nothing for that beat.
// - Selects sampled per beat; the two beats may use different patterns.
// - Selects act only in the data cycle of an accepted write.
// - Read of address written the cycle before returns the new data.
`timescale 1ns/1ps
module dsm_ddr_sram_core
  import dsm_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  input  wire logic              CORE_CLK_I,
  input  wire logic              SRST_I,
  input  wire logic              CE_I,
  input  wire logic              LOAD_STROBE_N_I,
  input  wire logic              RD_WR_N_I,
  input  wire logic [AW-1:0]     ADDR_I,
  input  wire logic [DATA_W-1:0] WR_DATA_RISE_I,
  input  wire logic [LANES-1:0]  LANE_MASK_RISE_N_I,
  input  wire logic [DATA_W-1:0] WR_DATA_FALL_I,
  input  wire logic [LANES-1:0]  LANE_MASK_FALL_N_I,
  output logic                   RD_VALID_O,
  output logic      [DATA_W-1:0] RD_BEAT0_O,
  output logic      [DATA_W-1:0] RD_BEAT1_O
);
  localparam int NL = BURST_BEATS * LANES;
  localparam int WW = BURST_BEATS * DATA_W;

  initial begin
    if (AW < 2 || LANES * LANE_W != DATA_W) begin
      $error("dsm_ddr_sram_core: bad geometry");
    end
  end

  // ****************************************
  // Command decode
  // ****************************************
  wire cmd_wr = !LOAD_STROBE_N_I && !RD_WR_N_I;
  wire cmd_rd = !LOAD_STROBE_N_I && RD_WR_N_I;

  logic          wr_phase_r;
  logic [AW-1:0] wr_addr_r;
  logic          rd_phase_r;
  logic          rd_lsb_r;

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      wr_phase_r <= 1'b0;
      rd_phase_r <= 1'b0;
      wr_addr_r  <= '0;
      rd_lsb_r   <= 1'b0;
    end else if (CE_I) begin
      wr_phase_r <= cmd_wr;
      rd_phase_r <= cmd_rd;
      if (cmd_wr) begin
        wr_addr_r <= ADDR_I;
      end
      if (cmd_rd) begin
        rd_lsb_r <= ADDR_I[0];
      end
    end
  end

  // ****************************************
  // Lane enables per beat
  // ****************************************
  logic [LANES-1:0] en_rise;
  logic [LANES-1:0] en_fall;
  for (genvar g = 0; g < LANES; g++) begin : g_en
    // Each lane judged alone on its own beat
    assign en_rise[g] = wr_phase_r && !LANE_MASK_RISE_N_I[g];
    assign en_fall[g] = wr_phase_r && !LANE_MASK_FALL_N_I[g];
  end

  // First beat lands at the loaded address, second at its partner
  wire           first_hi = wr_addr_r[0];
  wire [NL-1:0]  wr_lane  = first_hi ? {en_rise, en_fall} : {en_fall, en_rise};
  wire [WW-1:0]  wr_word  = first_hi ? {WR_DATA_RISE_I, WR_DATA_FALL_I}
                                     : {WR_DATA_FALL_I, WR_DATA_RISE_I};
  wire [AW-2:0]  wr_waddr = wr_addr_r[AW-1:1];

  // ****************************************
  // Array
  // ****************************************
  logic [WW-1:0] ram_rd;

  dsm_pair_ram #(
    .AW (AW - 1),
    .NL (NL),
    .LW (LANE_W)
  ) u_ram (
    .clk_i     (CORE_CLK_I),
    .ce_i      (CE_I),
    .wr_lane_i (wr_lane),
    .wr_addr_i (wr_waddr),
    .wr_data_i (wr_word),
    .rd_en_i   (cmd_rd),
    .rd_addr_i (ADDR_I[AW-1:1]),
    .rd_data_o (ram_rd)
  );

  // ****************************************
  // Forwarding of a same-cycle write
  // ****************************************
  wire fwd_hit = cmd_rd && wr_phase_r && (ADDR_I[AW-1:1] == wr_waddr);

  logic [NL-1:0] fwd_lane_r;
  logic [WW-1:0] fwd_data_r;

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      fwd_lane_r <= '0;
      fwd_data_r <= '0;
    end else if (CE_I) begin
      fwd_lane_r <= fwd_hit ? wr_lane : '0;
      fwd_data_r <= wr_word;
    end
  end

  logic [WW-1:0] merged;
  for (genvar g = 0; g < NL; g++) begin : g_fwd
    assign merged[g*LANE_W +: LANE_W] = fwd_lane_r[g] ? fwd_data_r[g*LANE_W +: LANE_W]
                                                      : ram_rd[g*LANE_W +: LANE_W];
  end

  wire [DATA_W-1:0] beat0 = rd_lsb_r ? merged[WW-1:DATA_W] : merged[DATA_W-1:0];
  wire [DATA_W-1:0] beat1 = rd_lsb_r ? merged[DATA_W-1:0]  : merged[WW-1:DATA_W];

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      RD_VALID_O <= 1'b0;
      RD_BEAT0_O <= DATA_RST;
      RD_BEAT1_O <= DATA_RST;
    end else if (CE_I) begin
      RD_VALID_O <= rd_phase_r;
      if (rd_phase_r) begin
        RD_BEAT0_O <= beat0;
        RD_BEAT1_O <= beat1;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_lane0_write: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (wr_phase_r && !LANE_MASK_RISE_N_I[0]) |->
      wr_lane[first_hi ? LANES : 0] && wr_word[(first_hi ? WW/2 : 0) +: LANE_W] ==
      WR_DATA_RISE_I[8:0])
    else $error("lane 0 not written");
  a_lane1_keep: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (LANE_MASK_RISE_N_I[1]) |-> !wr_lane[first_hi ? LANES + 1 : 1])
    else $error("lane 1 written while masked");
  a_lane2_keep: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (LANE_MASK_FALL_N_I[2]) |-> !wr_lane[first_hi ? 2 : LANES + 2])
    else $error("lane 2 written while masked");
  a_lane3_write: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (wr_phase_r && !LANE_MASK_FALL_N_I[3]) |-> wr_lane[first_hi ? 3 : LANES + 3])
    else $error("lane 3 not written");
  a_full_beat: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (wr_phase_r && LANE_MASK_RISE_N_I == 4'h0) |->
      (first_hi ? wr_lane[NL-1:LANES] : wr_lane[LANES-1:0]) == 4'hf)
    else $error("full beat not written");
  a_no_write: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (LANE_MASK_RISE_N_I == 4'hf && LANE_MASK_FALL_N_I == 4'hf) |-> wr_lane == '0)
    else $error("write with all masked");
  a_idle_ignore: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    $past(!cmd_wr || !CE_I) && !$past(SRST_I) && $past(CE_I) |-> wr_lane == '0)
    else $error("write outside data phase");
  a_beat_indep: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    wr_phase_r |-> $countones(wr_lane) ==
      $countones(~LANE_MASK_RISE_N_I) + $countones(~LANE_MASK_FALL_N_I))
    else $error("beat lanes not independent");
  a_fwd_read: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (CE_I && fwd_hit && wr_lane[0]) ##1 CE_I |->
      ##1 (RD_VALID_O && ($past(ADDR_I[0], 2) ? RD_BEAT1_O[8:0] : RD_BEAT0_O[8:0]) ==
      $past(wr_word[8:0], 2)))
    else $error("forwarded data missing");

  // ****************************************
  // Command, read and freeze checks
  // ****************************************
  a_wr_accept: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    CE_I |=> wr_phase_r == $past(cmd_wr))
    else $error("write data phase not tracking command");
  a_rd_latency: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    (CE_I && cmd_rd) ##1 CE_I |-> ##1 RD_VALID_O)
    else $error("read valid late");
  a_reset_quiet: assert property (@(posedge CORE_CLK_I)
    SRST_I |=> !RD_VALID_O && !wr_phase_r &&
      RD_BEAT0_O == DATA_RST && RD_BEAT1_O == DATA_RST)
    else $error("outputs not cleared by reset");
  a_beats_hold: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    !(CE_I && rd_phase_r) |=> $stable(RD_BEAT0_O) && $stable(RD_BEAT1_O))
    else $error("read beats moved without a read");
  a_freeze_hold: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    !CE_I |=> $stable(wr_phase_r) && $stable(rd_phase_r) &&
      $stable(RD_VALID_O) && $stable(fwd_lane_r))
    else $error("state moved while clock enable low");

  // ****************************************
  // Lane placement checks
  // ****************************************
  for (genvar g = 0; g < LANES; g++) begin : g_lane_chk
    a_lane_data: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
      (wr_phase_r && !LANE_MASK_RISE_N_I[g]) |-> wr_lane[(first_hi ? LANES : 0) + g] &&
        wr_word[(first_hi ? DATA_W : 0) + g*LANE_W +: LANE_W] ==
        WR_DATA_RISE_I[g*LANE_W +: LANE_W])
      else $error("rise lane misplaced");
    a_fall_data: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
      (wr_phase_r && !LANE_MASK_FALL_N_I[g]) |-> wr_lane[(first_hi ? 0 : LANES) + g] &&
        wr_word[(first_hi ? 0 : DATA_W) + g*LANE_W +: LANE_W] ==
        WR_DATA_FALL_I[g*LANE_W +: LANE_W])
      else $error("fall lane misplaced");
  end
endmodule : dsm_ddr_sram_core

//--- rtl/dsm_pair_ram.sv
// Purpose: Burst-pair memory with per-lane write enables
// Assumes: Read data registered; read sees array before same-edge write
// Notes:   No reset on contents
`timescale 1ns/1ps
module dsm_pair_ram
  import dsm_pkg::*;
#(
  parameter int AW  = ADDR_W - 1,
  parameter int NL  = 2 * LANES,
  parameter int LW  = LANE_W
) (
  input  wire logic             clk_i,
  input  wire logic             ce_i,
  input  wire logic [NL-1:0]    wr_lane_i,
  input  wire logic [AW-1:0]    wr_addr_i,
  input  wire logic [NL*LW-1:0] wr_data_i,
  input  wire logic             rd_en_i,
  input  wire logic [AW-1:0]    rd_addr_i,
  output logic      [NL*LW-1:0] rd_data_o
);
  initial begin
    if (AW < 1 || NL < 1 || LW < 1) begin
      $error("dsm_pair_ram: bad geometry");
    end
  end

  logic [NL*LW-1:0] mem [2**AW];
  logic [NL*LW-1:0] bit_en;

  always_ff @(posedge clk_i) begin
    if (ce_i && rd_en_i) begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

  // ****************************************
  // Per-lane write
  // ****************************************
  for (genvar g = 0; g < NL; g++) begin : g_lane
    assign bit_en[g*LW +: LW] = {LW{wr_lane_i[g]}};
  end

  // One process owns the array; masked lanes keep their old bits
  always_ff @(posedge clk_i) begin
    if (ce_i && (|wr_lane_i)) begin
      mem[wr_addr_i] <= (mem[wr_addr_i] & ~bit_en) | (wr_data_i & bit_en);
    end
  end
endmodule : dsm_pair_ram

//--- tb/dsm_host_model.sv
// Purpose: Host model issuing write and read bursts
// Assumes: Inputs move 1 ns after the rising edge
// Notes:   Idle cycles hold stray low selects and inverted data
`timescale 1ns/1ps
module dsm_host_model
  import dsm_pkg::*;
#(
  parameter int AW = 4
) (
  input  wire logic              clk_i,
  output logic                   ce_o,
  output logic                   load_n_o,
  output logic                   rd_wr_n_o,
  output logic      [AW-1:0]     addr_o,
  output logic      [DATA_W-1:0] d_rise_o,
  output logic      [LANES-1:0]  m_rise_o,
  output logic      [DATA_W-1:0] d_fall_o,
  output logic      [LANES-1:0]  m_fall_o,
  input  wire logic              valid_i,
  input  wire logic [DATA_W-1:0] beat0_i,
  input  wire logic [DATA_W-1:0] beat1_i
);
  task automatic idle();
    ce_o     = 1'b1;
    load_n_o = 1'b1;
    m_rise_o = 4'h0;
    m_fall_o = 4'h0;
    d_rise_o = ~d_rise_o;
    d_fall_o = ~d_fall_o;
  endtask : idle
  task automatic cmd(input logic [AW-1:0] a, input logic rd);
    @(posedge clk_i);
    #1;
    load_n_o  = 1'b0;
    rd_wr_n_o = rd;
    addr_o    = a;
    @(posedge clk_i);
    #1;
  endtask : cmd
  task automatic wr(input logic [AW-1:0] a, input logic [DATA_W-1:0] d0,
                    input logic [LANES-1:0] m0, input logic [DATA_W-1:0] d1,
                    input logic [LANES-1:0] m1, input logic fwd);
    cmd(a, 1'b0);
    load_n_o  = ~fwd;
    rd_wr_n_o = 1'b1;
    d_rise_o  = d0;
    m_rise_o  = m0;
    d_fall_o  = d1;
    m_fall_o  = m1;
    @(posedge clk_i);
    #1;
    idle();
  endtask : wr
  task automatic get(output logic [DATA_W-1:0] b0, output logic [DATA_W-1:0] b1,
                     output logic ok);
    ok = 1'b0;
    repeat (4) begin
      @(posedge clk_i);
      #1;
      if (!ok && valid_i === 1'b1) begin
        ok = 1'b1;
        b0 = beat0_i;
        b1 = beat1_i;
      end
    end
  endtask : get
  task automatic freeze(input int n);
    ce_o = 1'b0;
    repeat (n) @(posedge clk_i);
    #1;
    ce_o = 1'b1;
  endtask : freeze
  initial begin
    d_rise_o  = '0;
    d_fall_o  = '0;
    rd_wr_n_o = 1'b1;
    addr_o    = '0;
    idle();
  end
endmodule : dsm_host_model

//--- tb/tb_top.sv
// Purpose: Self-checking bench for lane-masked writes
// Assumes: Reset held 20 cycles
// Notes:   Reference words kept per address
`timescale 1ns/1ps
module tb_top;
  import dsm_pkg::*;
  localparam int AW = 4;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic ce, ld_n, rw_n, vld;
  logic [AW-1:0] addr;
  logic [DATA_W-1:0] dr, df, b0, b1;
  logic [LANES-1:0] mr, mf;
  logic [DATA_W-1:0] exp_mem [0:15];
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  always #2.5 core_clk = ~core_clk;
  dsm_host_model #(.AW(AW)) host (.clk_i(core_clk), .ce_o(ce), .load_n_o(ld_n),
    .rd_wr_n_o(rw_n), .addr_o(addr), .d_rise_o(dr), .m_rise_o(mr), .d_fall_o(df),
    .m_fall_o(mf), .valid_i(vld), .beat0_i(b0), .beat1_i(b1));
  dsm_ddr_sram_core #(.AW(AW)) dut_u (.CORE_CLK_I(core_clk), .SRST_I(srst), .CE_I(ce),
    .LOAD_STROBE_N_I(ld_n), .RD_WR_N_I(rw_n), .ADDR_I(addr), .WR_DATA_RISE_I(dr),
    .LANE_MASK_RISE_N_I(mr), .WR_DATA_FALL_I(df), .LANE_MASK_FALL_N_I(mf),
    .RD_VALID_O(vld), .RD_BEAT0_O(b0), .RD_BEAT1_O(b1));
  task automatic summarize();
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      summarize();
    end
  end
  task automatic check(input string nm, input logic [DATA_W-1:0] s, e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  function automatic logic [DATA_W-1:0] merge(logic [DATA_W-1:0] o, n, logic [3:0] m);
    for (int i = 0; i < LANES; i++) if (!m[i]) o[i*LANE_W +: LANE_W] = n[i*LANE_W +: LANE_W];
    return o;
  endfunction : merge
  task automatic do_wr(logic [AW-1:0] a, logic [DATA_W-1:0] d0, logic [3:0] m0,
                       logic [DATA_W-1:0] d1, logic [3:0] m1, logic fwd);
    exp_mem[a]      = merge(exp_mem[a], d0, m0);
    exp_mem[a ^ 1]  = merge(exp_mem[a ^ 1], d1, m1);
    host.wr(a, d0, m0, d1, m1, fwd);
  endtask : do_wr
  task automatic chk_rd(logic [AW-1:0] a, logic issue);
    logic [DATA_W-1:0] r0, r1;
    logic ok;
    if (issue) host.cmd(a, 1'b1);
    if (issue) host.idle();
    host.get(r0, r1, ok);
    check("rd_valid", {35'h0, ok}, 36'h1);
    check("beat0", r0, exp_mem[a]);
    check("beat1", r1, exp_mem[a ^ 1]);
  endtask : chk_rd
  task automatic t_full();
    for (int a = 0; a < 16; a += 2) begin
      do_wr(AW'(a), 36'h123456789 ^ a, 4'h0, 36'hedcba9876, 4'h0, 1'b0);
    end
    chk_rd(4'h6, 1'b1);
  endtask : t_full
  task automatic t_lanes();
    for (int i = 0; i < LANES; i++) begin
      do_wr(4'h5, 36'h0, ~(4'h1 << i), 36'hfffffffff, ~(4'h8 >> i), 1'b0);
      chk_rd(4'h5, 1'b1);
    end
  endtask : t_lanes
  task automatic t_none();
    do_wr(4'ha, 36'h0, 4'hf, 36'h0, 4'hf, 1'b0);
    repeat (3) @(posedge core_clk);
    chk_rd(4'ha, 1'b1);
  endtask : t_none
  task automatic t_fwd();
    do_wr(4'h8, 36'h5a5a5a5a5, 4'ha, 36'ha5a5a5a5a, 4'h5, 1'b1);
    chk_rd(4'h8, 1'b0);
  endtask : t_fwd
  task automatic t_freeze();
    host.cmd(4'h6, 1'b1);
    host.idle();
    host.freeze(3);
    chk_rd(4'h6, 1'b0);
  endtask : t_freeze
  initial begin
    repeat (20) @(posedge core_clk);
    #1;
    srst = 1'b0;
    t_full();
    t_lanes();
    t_none();
    t_fwd();
    t_freeze();
    summarize();
  end
endmodule : tb_top
